// ==== design/ee_params.svh ====
// Constants for the two-wire EEPROM link: layout, field positions and timing
// Functional notes
// - Array is 32 pages of 16 bytes
// - First byte after Start carries type identifier
// - Bits 3 and 2 match select pins
// - Bit 1 is byte address top bit
// - Bit 0 high reads, low writes
// - Acknowledge only a matching device address
// - Word address byte loads low eight bits
// - Byte write programs at the closing Stop
// - Ignore all traffic while programming runs
// - Page write takes up to 16 bytes
// - Acknowledge every data byte, program at Stop
// - Only low four address bits increment
// - Master caps a frame at 16 bytes but may run past the page end, which wraps
// - No acknowledge to write address while busy
// - Master polls with write address until acknowledged
// - Protect pin high blocks upper half writes
// - Protect pin sampled at Stop only
// - Protected write acknowledged, programming skipped
// - Receiver pulls data low on ninth clock
`ifndef EE_PARAMS_SVH
`define EE_PARAMS_SVH

`define EE_PAGES 32
`define EE_PAGE_BYTES 16
`define EE_MEM_BYTES 512
`define EE_ADDR_W 9
// Device type code: value is arbitrary
`define EE_DEV_TYPE 4'h5
`define EE_TYPE_MSB 7
`define EE_TYPE_LSB 4
`define EE_SEL_HI_BIT 3
`define EE_SEL_LO_BIT 2
`define EE_A8_BIT 1
`define EE_RW_BIT 0
`define EE_BIT_ACK 4'h8
`define EE_BIT_LAST 4'h7
`define EE_BIT_AFTER_START 4'h2
`define EE_CLK_NS 100
`define EE_PROG_TIME_NS 100000
`define EE_PROG_CYC ((`EE_PROG_TIME_NS + `EE_CLK_NS - 1) / `EE_CLK_NS)
`define EE_QUARTER_CYC 2'h2
`define EE_MAX_LEN 5'h10

`endif

// ==== design/ee_pkg.sv ====
// Types shared by both ends of the two-wire EEPROM link
package ee_pkg;
	typedef logic [7:0] ee_byte_t;
	typedef logic [8:0] ee_addr_t;
	typedef logic [15:0] ee_mask_t;
	typedef enum logic [1:0] {EE_ST_DEV, EE_ST_WORD, EE_ST_DATA} ee_stage_e;
	typedef enum logic [1:0] {EE_M_IDLE, EE_M_START, EE_M_BIT, EE_M_STOP} ee_mst_state_e;
endpackage

// ==== design/ee_link_if.sv ====
// Two-wire link between bus master and EEPROM, open-drain data line resolved here
`timescale 1ns/10ps
interface ee_link_if;
	logic scl;
	logic sda_m_o;
	logic sda_m_oe_n;
	logic sda_s_o;
	logic sda_s_oe_n;
	logic sda;

	// Wired-AND with pull-up: a released driver reads as high
	assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);

	modport master
	(
		output scl,
		output sda_m_o,
		output sda_m_oe_n,
		input sda
	);
	modport slave
	(
		input scl,
		input sda,
		output sda_s_o,
		output sda_s_oe_n
	);
endinterface

// ==== design/ee_dev.sv ====
// EEPROM end: address decode, byte and page write, self-timed programming
`timescale 1ns/10ps
`include "ee_params.svh"
module ee_dev
	import ee_pkg::*;
#(
	parameter int PROG_CYCLES = `EE_PROG_CYC
)
(
	input wire logic clock,
	input wire logic rst,
	ee_link_if.slave link,
	input wire logic slave_select_hi_pin,
	input wire logic slave_select_lo_pin,
	input wire logic wp_pin,
	input wire logic [8:0] mon_addr,
	output logic [7:0] mon_data,
	output logic busy
);

	logic start_det;
	logic start_clr;
	logic start_s1;
	logic start_s2;
	logic stop_det;
	logic stop_clr;
	logic stop_s1;
	logic stop_s2;
	logic stop_seen_r;
	logic stop_pulse;
	logic busy_r;
	logic busy_s1;
	logic busy_s2;
	logic sel_hi_s1;
	logic sel_hi_s2;
	logic sel_lo_s1;
	logic sel_lo_s2;
	logic wp_s1;
	logic wp_s2;
	logic [3:0] bit_cnt_r;
	ee_byte_t shift_r;
	ee_byte_t new_byte;
	logic byte_done;
	ee_stage_e stage_r;
	logic wr_act_r;
	logic ack_want_r;
	logic drive_r;
	ee_addr_t addr_r;
	ee_mask_t mask_r;
	ee_byte_t page_buf [`EE_PAGE_BYTES];
	ee_byte_t mem [`EE_MEM_BYTES];
	logic protect;
	logic prog_go;
	logic [15:0] prog_cnt_r;

	function automatic logic dev_match(input ee_byte_t b, input logic hi, input logic lo);
		dev_match = (b[`EE_TYPE_MSB:`EE_TYPE_LSB] == `EE_DEV_TYPE) &&
			(b[`EE_SEL_HI_BIT] == hi) && (b[`EE_SEL_LO_BIT] == lo);
	endfunction

	// Start: data falls while clock is high; cleared once the clock domain has it
	assign start_clr = rst | start_s2;
	always_ff @(negedge link.sda or posedge start_clr)
	begin
		if (start_clr)
			start_det <= 1'b0;
		else if (link.scl)
			start_det <= 1'b1;
	end

	// Stop: data rises while clock is high; the link clock stands still after it
	assign stop_clr = rst | stop_seen_r;
	always_ff @(posedge link.sda or posedge stop_clr)
	begin
		if (stop_clr)
			stop_det <= 1'b0;
		else if (link.scl)
			stop_det <= 1'b1;
	end

	// Start crosses on falling then rising clock, so it lands on the second data bit
	always_ff @(negedge link.scl or posedge rst)
	begin
		if (rst)
			start_s1 <= 1'b0;
		else
			start_s1 <= start_det;
	end

	always_ff @(posedge link.scl or posedge rst)
	begin
		if (rst)
		begin
			start_s2 <= 1'b0;
			busy_s1 <= 1'b0;
			busy_s2 <= 1'b0;
			sel_hi_s1 <= 1'b0;
			sel_hi_s2 <= 1'b0;
			sel_lo_s1 <= 1'b0;
			sel_lo_s2 <= 1'b0;
		end
		else
		begin
			start_s2 <= start_s1;
			busy_s1 <= busy_r;
			busy_s2 <= busy_s1;
			sel_hi_s1 <= slave_select_hi_pin;
			sel_hi_s2 <= sel_hi_s1;
			sel_lo_s1 <= slave_select_lo_pin;
			sel_lo_s2 <= sel_lo_s1;
		end
	end

	// Bit counter: 0..7 data bits, 8 is the acknowledge clock
	always_ff @(posedge link.scl or posedge rst)
	begin
		if (rst)
			bit_cnt_r <= 4'h0;
		else if (start_s2)
			bit_cnt_r <= `EE_BIT_AFTER_START;
		else if (bit_cnt_r == `EE_BIT_ACK)
			bit_cnt_r <= 4'h0;
		else
			bit_cnt_r <= bit_cnt_r + 4'h1;
	end

	always_ff @(posedge link.scl or posedge rst)
	begin
		if (rst)
			shift_r <= 8'h00;
		else
			shift_r <= new_byte;
	end

	assign new_byte = {shift_r[6:0], link.sda};
	assign byte_done = !start_s2 && (bit_cnt_r == `EE_BIT_LAST);

	// Byte stage and write session; a fresh Start always reframes
	always_ff @(posedge link.scl or posedge rst)
	begin
		if (rst)
		begin
			stage_r <= EE_ST_DEV;
			wr_act_r <= 1'b0;
			ack_want_r <= 1'b0;
		end
		else if (start_s2)
		begin
			stage_r <= EE_ST_DEV;
			wr_act_r <= 1'b0;
			ack_want_r <= 1'b0;
		end
		else if (byte_done)
		begin
			unique case (stage_r)
				EE_ST_DEV:
				begin
					// Busy array answers nothing, which is what polling relies on
					ack_want_r <= dev_match(new_byte, sel_hi_s2, sel_lo_s2) && !busy_s2;
					wr_act_r <= dev_match(new_byte, sel_hi_s2, sel_lo_s2) && !busy_s2 &&
						!new_byte[`EE_RW_BIT];
					stage_r <= EE_ST_WORD;
				end
				EE_ST_WORD:
				begin
					ack_want_r <= wr_act_r;
					stage_r <= EE_ST_DATA;
				end
				EE_ST_DATA:
				begin
					ack_want_r <= wr_act_r;
				end
				default:
				begin
					ack_want_r <= 1'b0;
					stage_r <= EE_ST_DEV;
				end
			endcase
		end
	end

	// Address: top bit from the device byte, rest from the word byte
	always_ff @(posedge link.scl or posedge rst)
	begin
		if (rst)
			addr_r <= 9'h000;
		else if (byte_done && stage_r == EE_ST_DEV && !new_byte[`EE_RW_BIT])
			addr_r[8] <= new_byte[`EE_A8_BIT];
		else if (byte_done && stage_r == EE_ST_WORD && wr_act_r)
			addr_r[7:0] <= new_byte;
		else if (byte_done && stage_r == EE_ST_DATA && wr_act_r)
			addr_r[3:0] <= addr_r[3:0] + 4'h1;
	end

	// Page latch: overrun wraps inside the page and overwrites earlier bytes
	always_ff @(posedge link.scl or posedge rst)
	begin
		if (rst)
			mask_r <= 16'h0000;
		else if (start_s2)
			mask_r <= 16'h0000;
		else if (byte_done && stage_r == EE_ST_DATA && wr_act_r)
			mask_r[addr_r[3:0]] <= 1'b1;
	end

	always_ff @(posedge link.scl)
	begin
		if (byte_done && stage_r == EE_ST_DATA && wr_act_r)
			page_buf[addr_r[3:0]] <= new_byte;
	end

	// Acknowledge held from the falling edge before the ninth clock to the one after
	always_ff @(negedge link.scl or posedge rst)
	begin
		if (rst)
			drive_r <= 1'b0;
		else
			drive_r <= (bit_cnt_r == `EE_BIT_ACK) && ack_want_r;
	end

	assign link.sda_s_o = 1'b0;
	assign link.sda_s_oe_n = ~drive_r;

	// Stop handshake into the system clock
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			stop_s1 <= 1'b0;
			stop_s2 <= 1'b0;
			stop_seen_r <= 1'b0;
		end
		else
		begin
			stop_s1 <= stop_det;
			stop_s2 <= stop_s1;
			stop_seen_r <= stop_s2;
		end
	end

	assign stop_pulse = stop_s2 & ~stop_seen_r;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wp_s1 <= 1'b0;
			wp_s2 <= 1'b0;
		end
		else
		begin
			wp_s1 <= wp_pin;
			wp_s2 <= wp_s1;
		end
	end

	// Page address and latch are quiet after Stop since the link clock has halted
	assign protect = wp_s2 && addr_r[8];
	assign prog_go = !rst && !busy_r && stop_pulse && (mask_r != 16'h0000) && !protect;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			busy_r <= 1'b0;
			prog_cnt_r <= 16'h0000;
		end
		else if (busy_r)
		begin
			// Protect pin is not looked at again until the cycle ends
			if (prog_cnt_r == 16'h0001)
				busy_r <= 1'b0;
			prog_cnt_r <= prog_cnt_r - 16'h0001;
		end
		else if (prog_go)
		begin
			busy_r <= 1'b1;
			prog_cnt_r <= 16'(PROG_CYCLES);
		end
	end

	// Latched bytes of the page written in one clock; array kept flat as 512 bytes
	always_ff @(posedge clock)
	begin
		if (prog_go)
		begin
			for (int i = 0; i < `EE_PAGE_BYTES; i++)
			begin
				if (mask_r[i])
					mem[{addr_r[8:4], 4'(i)}] <= page_buf[i];
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			mon_data <= 8'h00;
		else
			mon_data <= mem[mon_addr];
	end

	assign busy = busy_r;

endmodule

// ==== design/ee_mst.sv ====
// Bus master end: generates the link clock and sends write and poll frames
`timescale 1ns/10ps
`include "ee_params.svh"
module ee_mst
	import ee_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	ee_link_if.master link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_sel,
	input wire logic [8:0] cmd_addr,
	input wire logic [4:0] cmd_len,
	input wire logic [7:0] wr_data,
	output logic wr_take,
	output logic done,
	output logic no_acknowledge_bit
);

	ee_mst_state_e state_r;
	logic [1:0] tick_r;
	logic [1:0] q_r;
	logic step;
	logic [3:0] bit_r;
	logic [4:0] byte_r;
	logic [4:0] len_r;
	logic [4:0] last_r;
	ee_byte_t sh_r;
	ee_addr_t addr_r;
	logic scl_r;
	logic oe_n_r;
	logic sda_s1;
	logic sda_s2;

	assign cmd_ready = (state_r == EE_M_IDLE);
	assign step = (tick_r == `EE_QUARTER_CYC - 2'h1);
	assign link.scl = scl_r;
	assign link.sda_m_o = 1'b0;
	assign link.sda_m_oe_n = oe_n_r;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end
		else
		begin
			sda_s1 <= link.sda;
			sda_s2 <= sda_s1;
		end
	end

	// Link clock divider: each bit is four quarters
	always_ff @(posedge clock)
	begin
		if (rst || state_r == EE_M_IDLE)
		begin
			tick_r <= 2'h0;
			q_r <= 2'h0;
		end
		else if (step)
		begin
			tick_r <= 2'h0;
			q_r <= q_r + 2'h1;
		end
		else
			tick_r <= tick_r + 2'h1;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_r <= EE_M_IDLE;
			scl_r <= 1'b1;
			oe_n_r <= 1'b1;
			bit_r <= 4'h0;
			byte_r <= 5'h00;
			len_r <= 5'h00;
			last_r <= 5'h00;
			sh_r <= 8'h00;
			addr_r <= 9'h000;
			wr_take <= 1'b0;
			done <= 1'b0;
			no_acknowledge_bit <= 1'b0;
		end
		else
		begin
			wr_take <= 1'b0;
			done <= 1'b0;
			unique case (state_r)
				EE_M_IDLE:
				begin
					if (cmd_valid)
					begin
						// Never more than one page; zero length is a completion poll
						len_r <= (cmd_len > `EE_MAX_LEN) ? `EE_MAX_LEN : cmd_len;
						last_r <= (cmd_len == 5'h00) ? 5'h00 :
							((cmd_len > `EE_MAX_LEN) ? `EE_MAX_LEN : cmd_len) + 5'h01;
						addr_r <= cmd_addr;
						sh_r <= {`EE_DEV_TYPE, cmd_sel, cmd_addr[8], 1'b0};
						no_acknowledge_bit <= 1'b0;
						scl_r <= 1'b0;
						state_r <= EE_M_START;
					end
				end
				EE_M_START:
				begin
					if (step)
					begin
						unique case (q_r)
							2'h0: oe_n_r <= 1'b1;
							2'h1: scl_r <= 1'b1;
							2'h2: oe_n_r <= 1'b0;
							2'h3:
							begin
								scl_r <= 1'b0;
								bit_r <= 4'h0;
								byte_r <= 5'h00;
								state_r <= EE_M_BIT;
							end
						endcase
					end
				end
				EE_M_BIT:
				begin
					if (step)
					begin
						unique case (q_r)
							2'h0: oe_n_r <= (bit_r == `EE_BIT_ACK) ? 1'b1 : sh_r[7];
							2'h1: scl_r <= 1'b1;
							2'h2: scl_r <= 1'b1;
							2'h3:
							begin
								scl_r <= 1'b0;
								if (bit_r != `EE_BIT_ACK)
								begin
									bit_r <= bit_r + 4'h1;
									sh_r <= {sh_r[6:0], 1'b0};
								end
								else if (sda_s2)
								begin
									no_acknowledge_bit <= 1'b1;
									state_r <= EE_M_STOP;
								end
								else if (byte_r == last_r)
									state_r <= EE_M_STOP;
								else
								begin
									bit_r <= 4'h0;
									byte_r <= byte_r + 5'h01;
									if (byte_r == 5'h00)
										sh_r <= addr_r[7:0];
									else
									begin
										sh_r <= wr_data;
										wr_take <= 1'b1;
									end
								end
							end
						endcase
					end
				end
				EE_M_STOP:
				begin
					if (step)
					begin
						unique case (q_r)
							2'h0: oe_n_r <= 1'b0;
							2'h1: scl_r <= 1'b1;
							2'h2: oe_n_r <= 1'b1;
							2'h3:
							begin
								done <= 1'b1;
								state_r <= EE_M_IDLE;
							end
						endcase
					end
				end
			endcase
		end
	end

endmodule

// ==== tb/ee_link_assertions.sv ====
// Assertions on the two-wire link and the programming cycle
`timescale 1ns/10ps
module ee_link_assertions
#(
	parameter int PROG_CYCLES = 20
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_m_oe_n,
	input wire logic sda_s_oe_n,
	input wire logic busy
);
	logic [15:0] busy_cnt_r;
	logic [3:0] bit_cnt_r;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	always_ff @(posedge clock)
	begin
		if (rst || !busy)
			busy_cnt_r <= 16'h0000;
		else
			busy_cnt_r <= busy_cnt_r + 16'h0001;
	end

	// Start restarts the count, so count 8 marks the acknowledge slot
	always_ff @(posedge clock)
	begin
		if (rst || (scl && $past(scl) && $fell(sda)))
			bit_cnt_r <= 4'h0;
		else if ($rose(scl))
			bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : bit_cnt_r + 4'h1;
	end

	a_ack_one_period: assert property
		($fell(sda_s_oe_n) |-> (!sda_s_oe_n)[*8] ##1 sda_s_oe_n)
		else $error("ack length wrong");
	a_ack_ninth_bit: assert property
		($fell(sda_s_oe_n) |-> bit_cnt_r == 4'h8)
		else $error("ack outside ninth bit");
	a_ack_scl_low: assert property
		($changed(sda_s_oe_n) |-> !scl)
		else $error("device data moved with clock high");
	a_hold_scl_high: assert property
		(scl && $past(scl) |-> $stable(sda_s_oe_n))
		else $error("device data unstable");
	a_master_released: assert property
		(!sda_s_oe_n && scl |-> sda_m_oe_n)
		else $error("master drives during ack");
	a_busy_quiet: assert property
		(busy && $past(busy, 16) |-> sda_s_oe_n)
		else $error("ack while programming");
	a_busy_at_idle: assert property
		($rose(busy) |-> scl && sda)
		else $error("programming began inside a frame");
	a_busy_length: assert property
		($fell(busy) |-> busy_cnt_r == 16'(PROG_CYCLES))
		else $error("programming length wrong");
endmodule

// ==== tb/two_wire_eeprom_addr_write_bench.sv ====
// Bench joining bus master and EEPROM ends over the two-wire link
`timescale 1ns/10ps
module two_wire_eeprom_addr_write_bench
	import ee_pkg::*;
;
	localparam int PROG = 200;
	logic clock, rst, cmd_valid, cmd_ready, wr_take, done, no_acknowledge_bit, wp_pin, busy;
	logic [1:0] cmd_sel, sel_pins;
	logic [8:0] cmd_addr, mon_addr;
	logic [4:0] cmd_len;
	logic [7:0] wr_data, mon_data;
	int failures, tests_run, takes;

	ee_link_if u_ee_link_if();
	ee_mst u_ee_mst(.clock(clock), .rst(rst), .link(u_ee_link_if.master),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_sel(cmd_sel),
		.cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data),
		.wr_take(wr_take), .done(done), .no_acknowledge_bit(no_acknowledge_bit));
	ee_dev #(.PROG_CYCLES(PROG)) u_ee_dev(.clock(clock), .rst(rst),
		.link(u_ee_link_if.slave), .slave_select_hi_pin(sel_pins[1]),
		.slave_select_lo_pin(sel_pins[0]), .wp_pin(wp_pin), .mon_addr(mon_addr),
		.mon_data(mon_data), .busy(busy));
	ee_link_assertions #(.PROG_CYCLES(PROG)) u_ee_link_assertions(.clock(clock),
		.rst(rst), .scl(u_ee_link_if.scl), .sda(u_ee_link_if.sda),
		.sda_m_oe_n(u_ee_link_if.sda_m_oe_n),
		.sda_s_oe_n(u_ee_link_if.sda_s_oe_n), .busy(busy));

	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic test_done();
		$display("Comparisons %0d, failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One frame; the next data byte is presented after each take
	task automatic send(input logic [1:0] s, input logic [8:0] a, input logic [4:0] n,
		input logic [7:0] d);
		int k;
		logic t;
		k = 0;
		takes = 0;
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_sel <= s;
		cmd_addr <= a;
		cmd_len <= n;
		wr_data <= d;
		@(posedge clock);
		cmd_valid <= 1'b0;
		@(negedge clock);
		chk1(cmd_ready, 1'b0);
		while (done !== 1'b1 && k < 3000)
		begin
			t = wr_take;
			@(posedge clock);
			if (t === 1'b1)
			begin
				wr_data <= wr_data + 8'h01;
				takes++;
			end
			@(negedge clock);
			k++;
		end
		chk1(done, 1'b1);
		@(negedge clock);
	endtask

	task automatic wait_busy(input logic exp);
		logic seen;
		seen = 1'b0;
		repeat (12)
		begin
			@(negedge clock);
			if (busy === 1'b1)
				seen = 1'b1;
		end
		chk1(seen, exp);
	endtask

	task automatic poll_ack();
		int k;
		k = 0;
		send(2'b10, 9'h000, 5'h00, 8'h00);
		while (no_acknowledge_bit !== 1'b0 && k < 20)
		begin
			send(2'b10, 9'h000, 5'h00, 8'h00);
			k++;
		end
		chk1(no_acknowledge_bit, 1'b0);
	endtask

	task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
		@(posedge clock);
		mon_addr <= a;
		repeat (2) @(negedge clock);
		chk8(mon_data, exp);
	endtask

	task automatic t_byte();
		send(2'b10, 9'h123, 5'h01, 8'hA5);
		chk1(no_acknowledge_bit, 1'b0);
		chk8(8'(takes), 8'h01);
		wait_busy(1'b1);
		send(2'b10, 9'h000, 5'h00, 8'h00);
		chk1(no_acknowledge_bit, 1'b1);
		poll_ack();
		rd_chk(9'h123, 8'hA5);
	endtask

	task automatic t_mismatch();
		for (int i = 0; i < 4; i++)
		begin
			if (i != 2)
			begin
				send(2'(i), 9'h123, 5'h01, 8'h3C);
				chk1(no_acknowledge_bit, 1'b1);
				chk8(8'(takes), 8'h00);
				wait_busy(1'b0);
			end
		end
		rd_chk(9'h123, 8'hA5);
		// Strap levels moved so the match follows the pins, not a fixed code
		@(posedge clock);
		sel_pins <= 2'b01;
		send(2'b10, 9'h123, 5'h01, 8'h3C);
		chk1(no_acknowledge_bit, 1'b1);
		send(2'b01, 9'h123, 5'h01, 8'h3C);
		chk1(no_acknowledge_bit, 1'b0);
		wait_busy(1'b1);
		@(posedge clock);
		sel_pins <= 2'b10;
		poll_ack();
		rd_chk(9'h123, 8'h3C);
	endtask

	task automatic t_page();
		send(2'b10, 9'h04C, 5'h10, 8'h30);
		chk1(no_acknowledge_bit, 1'b0);
		chk8(8'(takes), 8'h10);
		wait_busy(1'b1);
		poll_ack();
		for (int i = 0; i < 16; i++)
			rd_chk({5'h04, 4'(4'hC + i)}, 8'(8'h30 + i));
	endtask

	// Pin changes are kept clear of Stop so the sampled level is certain
	task automatic t_protect();
		send(2'b10, 9'h180, 5'h01, 8'h55);
		wait_busy(1'b1);
		poll_ack();
		@(posedge clock);
		wp_pin <= 1'b1;
		send(2'b10, 9'h180, 5'h02, 8'h66);
		chk1(no_acknowledge_bit, 1'b0);
		wait_busy(1'b0);
		send(2'b10, 9'h000, 5'h00, 8'h00);
		chk1(no_acknowledge_bit, 1'b0);
		rd_chk(9'h180, 8'h55);
		send(2'b10, 9'h0F0, 5'h01, 8'h99);
		wait_busy(1'b1);
		poll_ack();
		@(posedge clock);
		wp_pin <= 1'b0;
		send(2'b10, 9'h181, 5'h01, 8'h77);
		wait_busy(1'b1);
		@(posedge clock);
		wp_pin <= 1'b1;
		poll_ack();
		rd_chk(9'h181, 8'h77);
		rd_chk(9'h0F0, 8'h99);
	endtask

	initial
	begin
		#(100 * 60000);
		failures++;
		test_done();
	end

	initial
	begin
		failures = 0;
		tests_run = 0;
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_sel = 2'b00;
		cmd_addr = 9'h000;
		cmd_len = 5'h00;
		wr_data = 8'h00;
		wp_pin = 1'b0;
		sel_pins = 2'b10;
		mon_addr = 9'h000;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		t_byte();
		t_mismatch();
		t_page();
		t_protect();
		test_done();
	end
endmodule
